//--- hw/pcc_pkg.sv
// package: register map, field positions, reset values and timing for the pll/clamp config block
package pcc_pkg;
  // register offsets (byte addresses are four times the index)
  localparam logic [7:0] PCC_IDX_PLL_MISC   = 8'h13;
  localparam logic [7:0] PCC_IDX_START_HIGH = 8'h14;
  localparam logic [7:0] PCC_IDX_START_LOW  = 8'h15;
  localparam logic [7:0] PCC_IDX_DAC_STAGE  = 8'h20;
  localparam logic [7:0] PCC_IDX_STATUS     = 8'h21;
  localparam logic [7:0] PCC_IDX_CLAMP_CFG  = 8'h22;
  localparam logic [7:0] PCC_IDX_DAC_LIVE   = 8'h23;
  // reset values
  localparam logic [7:0] PCC_RST_PLL_MISC   = 8'h04;
  localparam logic [7:0] PCC_RST_START_HIGH = 8'h00;
  localparam logic [7:0] PCC_RST_START_LOW  = 8'h03;
  localparam logic [7:0] PCC_RST_DAC        = 8'h80;
  localparam logic [7:0] PCC_RST_CLAMP_CFG  = 8'h03;
  // field positions in pll_misc_control
  localparam int PCC_BIT_LOCK_EDGE   = 0;
  localparam int PCC_BIT_PIN_DISABLE = 3;
  localparam int PCC_FN_LO           = 4;
  localparam int PCC_FN_HI           = 5;
  // field positions in the clamp configuration register, and widths of the clamp start registers
  localparam int PCC_BIT_DC_EN       = 0;
  localparam int PCC_BIT_COMP_EN     = 1;
  localparam int PCC_START_WIDTH     = 13;
  localparam int PCC_START_HIGH_BITS = 5;
  // pin function codes
  localparam logic [1:0] PCC_FN_CLOCK_INVERT = 2'h0;
  localparam logic [1:0] PCC_FN_EXT_CLAMP    = 2'h1;
  localparam logic [1:0] PCC_FN_EXT_COAST    = 2'h2;
  localparam logic [1:0] PCC_FN_EXT_PIXEL_CLOCK = 2'h3;
  // timing
  localparam int PCC_CLK_MHZ          = 100;
  localparam int PCC_UPDATE_MAX_MS    = 100;
  localparam int PCC_UPDATE_MAX_CYC   = PCC_UPDATE_MAX_MS * 1000 * PCC_CLK_MHZ;
  localparam int PCC_PIXCNT_WIDTH     = 13;
endpackage : pcc_pkg

//--- hw/pcc_wb_slave.sv
// classic wishbone slave front end: one-cycle registered ack, decode of word index
`timescale 1ns/1ps
`default_nettype none
module pcc_wb_slave
  import pcc_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // wishbone
  input  wire logic       wbCyc,
  input  wire logic       wbStb,
  input  wire logic       wbWe,
  input  wire logic [9:0] wbAdr,
  input  wire logic [3:0] wbSel,
  output var  logic       wbAck,
  // decoded access, valid in the ack cycle
  output logic            wrPulse,
  output logic            rdCycle,
  output logic [7:0]      regIdx
);
  typedef struct packed {
    logic ack;
  } pcc_wb_state_t;
  pcc_wb_state_t state_reg;
  pcc_wb_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // ack drops the cycle after it is given, so a held request is not acked in two cycles in a row
    state_next.ack = wbCyc && wbStb && !state_reg.ack;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wbAck   = state_reg.ack;
  assign wrPulse = state_reg.ack && wbWe && wbSel[0];
  assign rdCycle = state_reg.ack && !wbWe;
  assign regIdx  = wbAdr[9:2];
endmodule : pcc_wb_slave
`default_nettype wire

//--- hw/pcc_config.sv
// top: pll misc, multi-function pin routing, clamp pulse generation and offset dac update
`timescale 1ns/1ps
`default_nettype none
module pcc_config
  import pcc_pkg::*;
#(
  parameter int UPDATE_MAX_CYC = PCC_UPDATE_MAX_CYC
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // wishbone
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [9:0]  wbAdr,
  input  wire logic [31:0] wbDatW,
  input  wire logic [3:0]  wbSel,
  output var  logic [31:0] wbDatR,
  output var  logic        wbAck,
  // video timing
  input  wire logic        hsyncIn,
  input  wire logic        multiFunctionClockPin,
  // pll controls
  output var  logic        pllLockLeadingEdge,
  output var  logic        sampleClockInvert,
  output var  logic        externalCoast,
  output var  logic        externalPixelClockSel,
  output var  logic        externalPixelClock,
  // clamp outputs
  output var  logic        clampPulse,
  output var  logic        dcRestoreStart,
  output var  logic        blackCompStart,
  output var  logic [7:0]  offsetDacValue
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]                  pllMisc;
    logic [7:0]                  startHigh;
    logic [7:0]                  startLow;
    logic [7:0]                  clampCfg;
    logic [7:0]                  dacStage;
    logic [7:0]                  dacLive;
    logic                        dacPending;
    logic [31:0]                 waitCnt;
    logic [PCC_PIXCNT_WIDTH-1:0] pixCnt;
    logic                        counting;
    logic                        hsyncPrev;
    logic                        pinPrev;
    logic                        lockLead;
    logic                        sample_clock_invert;
    logic                        coast;
    logic                        pixSel;
    logic                        external_pixel_clock;
    logic                        clamp;
    logic                        dcStart;
    logic                        compStart;
    logic [31:0]                 rdData;
  } pcc_state_t;
  pcc_state_t state_reg;
  pcc_state_t state_next;

  logic       wrPulse;
  logic [7:0] regIdx;

  pcc_wb_slave u_wb (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wbCyc   (wbCyc),
    .wbStb   (wbStb),
    .wbWe    (wbWe),
    .wbAdr   (wbAdr),
    .wbSel   (wbSel),
    .wbAck   (wbAck),
    .wrPulse (wrPulse),
    .rdCycle (),
    .regIdx  (regIdx)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic                        pinLevel;
  logic [1:0]                  pinFn;
  logic                        hsTrail;
  logic                        pinRise;
  logic                        intClamp;
  logic                        clampNow;
  logic [PCC_PIXCNT_WIDTH-1:0] startPix;
  logic [7:0]                  wrByte;

  always_comb begin
    // only the low byte lane carries register data; the upper lanes are ignored
    wrByte   = wbDatW[7:0];
    pinFn    = state_reg.pllMisc[PCC_FN_HI:PCC_FN_LO];
    pinLevel = multiFunctionClockPin && !state_reg.pllMisc[PCC_BIT_PIN_DISABLE];
    startPix = {state_reg.startHigh[PCC_START_HIGH_BITS-1:0], state_reg.startLow};
    // hsync is active high; trailing edge is the fall
    hsTrail  = state_reg.hsyncPrev && !hsyncIn;
    // pinPrev clears at reset, but the pin function is clock invert then, so a pin already high there gives no external clamp
    pinRise  = pinLevel && !state_reg.pinPrev;
    intClamp = state_reg.counting && (state_reg.pixCnt == startPix);
    // external clamp replaces the internal one entirely
    clampNow = (pinFn == PCC_FN_EXT_CLAMP) ? pinRise : intClamp;

    state_next           = state_reg;
    state_next.hsyncPrev = hsyncIn;
    state_next.pinPrev   = pinLevel;

    // counting stops at the match, so each line gives one internal clamp
    if (hsTrail) begin
      state_next.counting = 1'b1;
      state_next.pixCnt   = '0;
    end else if (state_reg.counting) begin
      if (intClamp) begin
        state_next.counting = 1'b0;
      end else begin
        state_next.pixCnt = state_reg.pixCnt + 13'h0001;
      end
    end

    // timeout so a dac write still lands with no clamp at all
    if (state_reg.dacPending) begin
      state_next.waitCnt = state_reg.waitCnt + 32'h00000001;
    end
    if (clampNow || (state_reg.dacPending && state_reg.waitCnt >= 32'(UPDATE_MAX_CYC - 1))) begin
      state_next.dacLive    = state_reg.dacStage;
      state_next.dacPending = 1'b0;
      state_next.waitCnt    = '0;
    end

    state_next.clamp     = clampNow;
    state_next.dcStart   = clampNow && state_reg.clampCfg[PCC_BIT_DC_EN];
    state_next.compStart = clampNow && state_reg.clampCfg[PCC_BIT_COMP_EN];

    // the lock edge only steers the pll; the clamp counter always starts on the trailing edge
    state_next.lockLead = state_reg.pllMisc[PCC_BIT_LOCK_EDGE];
    state_next.sample_clock_invert   = 1'b0;
    state_next.coast    = 1'b0;
    state_next.pixSel   = 1'b0;
    state_next.external_pixel_clock   = 1'b0;
    unique case (pinFn)
      PCC_FN_CLOCK_INVERT: state_next.sample_clock_invert = pinLevel;
      PCC_FN_EXT_CLAMP:    ;
      PCC_FN_EXT_COAST:    state_next.coast = pinLevel;
      PCC_FN_EXT_PIXEL_CLOCK: begin
        state_next.pixSel = 1'b1;
        state_next.external_pixel_clock = pinLevel;
      end
    endcase

    if (wrPulse) begin
      unique case (regIdx)
        PCC_IDX_PLL_MISC:   state_next.pllMisc   = wrByte;
        // bits above the 13-bit start are not stored and read back as zero
        PCC_IDX_START_HIGH: state_next.startHigh = {3'h0, wrByte[4:0]};
        PCC_IDX_START_LOW:  state_next.startLow  = wrByte;
        PCC_IDX_CLAMP_CFG:  state_next.clampCfg  = {6'h00, wrByte[1:0]};
        PCC_IDX_DAC_STAGE: begin
          state_next.dacStage   = wrByte;
          // a write racing a clamp keeps the new value pending
          state_next.dacPending = 1'b1;
          state_next.waitCnt    = '0;
        end
        default: ;
      endcase
    end

    // read data is taken at the request edge, so it stands from a flop in the ack cycle
    state_next.rdData = '0;
    if (wbCyc && wbStb && !wbWe && !wbAck) begin
      unique case (regIdx)
        PCC_IDX_PLL_MISC:   state_next.rdData = {24'h000000, state_reg.pllMisc};
        PCC_IDX_START_HIGH: state_next.rdData = {24'h000000, state_reg.startHigh};
        PCC_IDX_START_LOW:  state_next.rdData = {24'h000000, state_reg.startLow};
        PCC_IDX_CLAMP_CFG:  state_next.rdData = {24'h000000, state_reg.clampCfg};
        PCC_IDX_DAC_STAGE:  state_next.rdData = {24'h000000, state_reg.dacStage};
        PCC_IDX_DAC_LIVE:   state_next.rdData = {24'h000000, state_reg.dacLive};
        PCC_IDX_STATUS:     state_next.rdData = {30'h00000000, state_reg.counting, state_reg.dacPending};
        default:            state_next.rdData = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg           <= '0;
      state_reg.pllMisc   <= PCC_RST_PLL_MISC;
      state_reg.startHigh <= PCC_RST_START_HIGH;
      state_reg.startLow  <= PCC_RST_START_LOW;
      state_reg.clampCfg  <= PCC_RST_CLAMP_CFG;
      // offset dacs sit at mid scale out of reset
      state_reg.dacStage  <= PCC_RST_DAC;
      state_reg.dacLive   <= PCC_RST_DAC;
    end else begin
      state_reg <= state_next;
    end
  end

  // read data and ack are both flops loaded at the request edge
  assign wbDatR                = state_reg.rdData;
  assign pllLockLeadingEdge    = state_reg.lockLead;
  assign sampleClockInvert     = state_reg.sample_clock_invert;
  assign externalCoast         = state_reg.coast;
  assign externalPixelClockSel = state_reg.pixSel;
  assign externalPixelClock    = state_reg.external_pixel_clock;
  assign clampPulse            = state_reg.clamp;
  assign dcRestoreStart        = state_reg.dcStart;
  assign blackCompStart        = state_reg.compStart;
  assign offsetDacValue        = state_reg.dacLive;
endmodule : pcc_config
`default_nettype wire

//--- verif/pcc_config_checker.sv
// checker: bus handshake, pin routing, clamp pulse and offset update relations
`timescale 1ns/1ps
`default_nettype none
module pcc_config_checker
  import pcc_pkg::*;
#(
  parameter int UPDATE_MAX_CYC = 50
)(
  // clock, reset and bus
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        wbCyc,
  input wire logic        wbStb,
  input wire logic        wbWe,
  input wire logic        wbAck,
  input wire logic [9:0]  wbAdr,
  input wire logic [31:0] wbDatW,
  input wire logic [31:0] wbDatR,
  input wire logic [3:0]  wbSel,
  // video side
  input wire logic        hsyncIn,
  input wire logic        multiFunctionClockPin,
  input wire logic        pllLockLeadingEdge,
  input wire logic        sampleClockInvert,
  input wire logic        externalCoast,
  input wire logic        externalPixelClockSel,
  input wire logic        externalPixelClock,
  input wire logic        clampPulse,
  input wire logic        dcRestoreStart,
  input wire logic        blackCompStart,
  input wire logic [7:0]  offsetDacValue
);
  localparam int DacWait = UPDATE_MAX_CYC + 10;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [7:0] idx;
  logic [7:0] stagedReg;
  assign idx = wbAdr[9:2];
  // stage value kept here so the update bound can compare against it
  always_ff @(posedge sys_clk) begin
    if (wbAck && wbWe && idx == PCC_IDX_DAC_STAGE) stagedReg <= wbDatW[7:0];
  end
  //////////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("ack longer than one cycle");
  ack_cause_a: assert property (wbAck |-> $past(wbCyc && wbStb)) else $error("ack without request");
  unmapped_zero_a: assert property (wbAck && !wbWe && idx == 8'h30 |-> wbDatR == 32'h0)
    else $error("unmapped read not zero");
  lock_edge_a:
    assert property (wbAck && wbWe && wbSel[0] && idx == PCC_IDX_PLL_MISC
      |-> ##3 pllLockLeadingEdge == $past(wbDatW[0], 3)) else $error("lock edge not taken");
  pin_role_a:
    assert property ($onehot0({sampleClockInvert, externalCoast, externalPixelClock})) else $error("two pin roles");
  pixel_clock_sel_a:
    assert property (externalPixelClock |-> externalPixelClockSel) else $error("pixel clock unselected");
  clamp_single_a:
    assert property (clampPulse |=> !clampPulse) else $error("clamp pulse too long");
  start_cause_a:
    assert property (dcRestoreStart || blackCompStart |-> clampPulse) else $error("start without clamp");
  start_gap_a:
    assert property ($fell(hsyncIn) |=> !clampPulse) else $error("clamp too early after sync");
  dac_update_a:
    assert property (wbAck && wbWe && wbSel[0] && idx == PCC_IDX_DAC_STAGE
      |-> ##[1:DacWait] offsetDacValue == stagedReg) else $error("offset update late");
endmodule : pcc_config_checker

bind pcc_config pcc_config_checker #(.UPDATE_MAX_CYC(UPDATE_MAX_CYC)) u_pcc_config_checker (
  .sys_clk, .rst, .wbCyc, .wbStb, .wbWe, .wbAck, .wbAdr, .wbDatW, .wbDatR, .wbSel, .hsyncIn,
  .multiFunctionClockPin, .pllLockLeadingEdge, .sampleClockInvert, .externalCoast, .externalPixelClockSel,
  .externalPixelClock, .clampPulse, .dcRestoreStart, .blackCompStart, .offsetDacValue);
`default_nettype wire

//--- verif/pcc_host.sv
// host model: classic wishbone master that programs the config registers
`timescale 1ns/1ps
`default_nettype none
module pcc_host
  import pcc_pkg::*;
(
  // clock and answer
  input  wire logic        sys_clk,
  input  wire logic        wbAck,
  input  wire logic [31:0] wbDatR,
  // request
  output logic             wbCyc,
  output logic             wbStb,
  output logic             wbWe,
  output logic [9:0]       wbAdr,
  output logic [31:0]      wbDatW,
  output logic [3:0]       wbSel
);
  initial begin
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW, wbSel} = '0;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    {wbCyc, wbStb, wbWe, wbSel} <= {1'b1, 1'b1, we, 4'hF};
    wbAdr <= {idx, 2'b00};
    wbDatW <= {24'h0, d};
    @(posedge sys_clk);
    while (wbAck !== 1'b1) @(posedge sys_clk);
    q = wbDatR[7:0];
    {wbCyc, wbStb} <= 2'b00;
    // released lines must not keep showing the old value
    wbAdr <= ~wbAdr;
    wbDatW <= ~wbDatW;
  endtask : xfer
  task automatic wrMisc(input logic [1:0] fn, input logic dis, input logic lock);
    logic [7:0] q;
    xfer(1'b1, PCC_IDX_PLL_MISC, {1'b1, 1'b0, fn, dis, 2'b00, lock}, q);
  endtask : wrMisc
  task automatic setStart(input logic [12:0] pix);
    logic [7:0] q;
    xfer(1'b1, PCC_IDX_START_HIGH, {3'h0, pix[12:8]}, q);
    xfer(1'b1, PCC_IDX_START_LOW, pix[7:0], q);
  endtask : setStart
endmodule : pcc_host
`default_nettype wire

//--- verif/testbench.sv
// testbench: register, pin routing, clamp timing and offset update tests
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin nChecks++; if ((got) !== (ex)) begin failCount++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench
  import pcc_pkg::*;
;
  localparam int UpdCyc = 50;
  logic sys_clk = 0, rst = 1, hsyncIn = 0, multiFunctionClockPin = 0;
  logic wbCyc, wbStb, wbWe, wbAck, pllLockLeadingEdge, sampleClockInvert, externalCoast;
  logic externalPixelClockSel, externalPixelClock, clampPulse, dcRestoreStart, blackCompStart;
  logic [9:0] wbAdr;
  logic [31:0] wbDatW, wbDatR;
  logic [3:0] wbSel;
  logic [7:0] offsetDacValue, q;
  logic [7:0] rstVals [3] = '{PCC_RST_PLL_MISC, PCC_RST_START_HIGH, PCC_RST_START_LOW};
  int failCount = 0, nChecks = 0, cycles = 0, n1, n2;
  always #5 sys_clk = ~sys_clk;
  pcc_config #(.UPDATE_MAX_CYC(UpdCyc)) u_pcc_config (.sys_clk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr,
    .wbDatW, .wbSel, .wbDatR, .wbAck, .hsyncIn, .multiFunctionClockPin, .pllLockLeadingEdge,
    .sampleClockInvert, .externalCoast, .externalPixelClockSel, .externalPixelClock, .clampPulse,
    .dcRestoreStart, .blackCompStart, .offsetDacValue);
  pcc_host u_pcc_host (.sys_clk, .wbAck, .wbDatR, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbDatW, .wbSel);
  //////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // one sync pulse, then count settled cycles until the clamp pulse
  task automatic clampTime(output int n);
    @(posedge sys_clk) hsyncIn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    hsyncIn <= 1'b0;
    n = 0;
    do begin @(posedge sys_clk); #1; n++; end while (clampPulse !== 1'b1 && n < 400);
  endtask : clampTime
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin failCount++; conclude(); end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      u_pcc_host.xfer(1'b0, 8'(PCC_IDX_PLL_MISC + i), 8'h00, q);
      `CHK("reset value", rstVals[i], q)
    end
    u_pcc_host.xfer(1'b0, 8'h30, 8'h00, q);
    `CHK("unmapped read", 8'h00, q)
    u_pcc_host.xfer(1'b1, PCC_IDX_START_HIGH, 8'hFF, q);
    u_pcc_host.xfer(1'b0, PCC_IDX_START_HIGH, 8'h00, q);
    `CHK("start high", 8'h1F, q)
    $display("test registers done");
    multiFunctionClockPin <= 1'b1;
    for (int f = 0; f < 8; f++) begin
      u_pcc_host.wrMisc(f[1:0], f[2], f[0]);
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("lock edge", f[0], pllLockLeadingEdge)
      `CHK("clock invert", f == 0, sampleClockInvert)
      `CHK("coast", f == 2, externalCoast)
      `CHK("pixel clock select", f[1:0] == 2'h3, externalPixelClockSel)
      `CHK("pixel clock", f == 3, externalPixelClock)
    end
    $display("test pin routing done");
    u_pcc_host.wrMisc(2'h0, 1'b0, 1'b0);
    multiFunctionClockPin <= 1'b0;
    u_pcc_host.setStart(13'h0005);
    clampTime(n1);
    `CHK("internal clamp", 1'b1, clampPulse)
    `CHK("restore start", 1'b1, dcRestoreStart)
    `CHK("comp start", 1'b1, blackCompStart)
    u_pcc_host.setStart(13'h0105);
    u_pcc_host.xfer(1'b1, PCC_IDX_CLAMP_CFG, 8'h00, q);
    clampTime(n2);
    `CHK("start distance", 256, n2 - n1)
    `CHK("restore off", 1'b0, dcRestoreStart)
    `CHK("comp off", 1'b0, blackCompStart)
    $display("test clamp timing done");
    u_pcc_host.xfer(1'b1, PCC_IDX_DAC_STAGE, 8'h3C, q);
    #1;
    `CHK("dac pending", 8'h80, offsetDacValue)
    u_pcc_host.xfer(1'b0, PCC_IDX_STATUS, 8'h00, q);
    `CHK("update pending", 8'h01, q)
    repeat (UpdCyc + 5) @(posedge sys_clk);
    #1;
    `CHK("dac timeout", 8'h3C, offsetDacValue)
    u_pcc_host.xfer(1'b0, PCC_IDX_DAC_LIVE, 8'h00, q);
    `CHK("live offset", 8'h3C, q)
    u_pcc_host.wrMisc(2'h1, 1'b0, 1'b0);
    u_pcc_host.xfer(1'b1, PCC_IDX_DAC_STAGE, 8'h55, q);
    repeat (5) @(posedge sys_clk);
    #1;
    `CHK("dac before edge", 8'h3C, offsetDacValue)
    @(posedge sys_clk);
    multiFunctionClockPin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("dac after edge", 8'h55, offsetDacValue)
    $display("test offset update done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
